// ==== rtl/tmr_pkg.sv ====
package tmr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register bus
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    localparam logic [3:0] OFS_COUNT_LOW      = 4'h0;
    localparam logic [3:0] OFS_COUNT_HIGH     = 4'h1;
    localparam logic [3:0] OFS_COUNTER_CTRL   = 4'h2;
    localparam logic [3:0] OFS_COMPANION_CTRL = 4'h3;
    localparam logic [3:0] OFS_PERIPH_FLAGS   = 4'h4;
    localparam logic [3:0] OFS_PERIPH_ENABLES = 4'h5;
    localparam logic [3:0] OFS_PERIPH_PRIO    = 4'h6;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned BIT_OVERFLOW    = 1;  // flags, enables and priority
    localparam int unsigned BIT_AUX_OSC_EN  = 3;  // companion timer control

    localparam logic [7:0] RST_COUNTER_CTRL   = 8'h00;
    localparam logic [7:0] RST_COMPANION_CTRL = 8'h00;
    localparam logic [7:0] RST_PERIPH         = 8'h00;
    localparam logic [7:0] COMPANION_MASK     = 8'hBF;  // bit 6 unimplemented
    localparam logic [7:0] PERIPH_MASK        = 8'h4F;  // bits 7, 5, 4 unimplemented

    localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONE  = 16'h0001;

    // compare unit mode that asks for a counter reset
    localparam logic [3:0] MODE_SPECIAL_TRIGGER = 4'b1011;

    // external clock synchroniser depth, used with and without sync bypass
    localparam int unsigned SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////
    // counter control layout, bit 7 down to bit 0
    typedef struct packed {
        logic       wide_access_enable;
        logic       ccp_select_hi;
        logic [1:0] input_prescale_select;
        logic       ccp_select_lo;
        logic       sync_bypass;
        logic       clock_source_select;
        logic       counter_run;
    } counter_ctrl_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

// ==== rtl/pin_sync.sv ====
module pin_sync #(
    parameter int unsigned STAGES = 2
) (
    input  wire logic i_core_clk,  // core clock
    input  wire logic i_rst,       // synchronous reset
    input  wire logic i_pin,       // asynchronous level
    output logic      o_level      // level after STAGES flops
);

    logic [STAGES-1:0] stage;

    // only the last stage is visible outside
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            stage <= '0;
        end else begin
            stage <= {stage[STAGES-2:0], i_pin};
        end
    end

    assign o_level = stage[STAGES-1];

endmodule // pin_sync

// ==== rtl/timer16_core.sv ====
// What this block does
// - three modes: timer, synchronous counter, asynchronous counter, by clock select and sync bypass.
// - clock select 0 advances the count every instruction cycle when the prescale code is 00.
// - clock select 1 advances on rising edges of pin or aux oscillator.
// - aux oscillator enabled makes both oscillator pins inputs, direction bits ignored.
// - sixteen-bit count runs 0000h to FFFFh then wraps to 0000h.
// - wrap latches overflow flag; interrupt only while its enable is set.
// - compare mode 1011 trigger pulse resets the count to zero.
// - trigger reset never sets the overflow flag.
// - a count write in the same cycle as a trigger wins.
// - with trigger reset the compare pair acts as period register.
// - aux oscillator runs only while its enable bit is set.
// - count bytes undefined after power-on, kept across other resets.
// - bit 7 picks one sixteen-bit access or two byte accesses.
// - prescale codes 00..11 divide the selected clock by 1, 2, 4, 8.
// - sync bypass bit 2 matters only with the external clock.
// - run bit 0 lets the counter advance; clear stops it.
//
// Local design decisions: the register addresses and the plain strobed port.
module timer16_core (
    input  wire logic        i_core_clk,        // instruction clock, 25 MHz
    input  wire logic        i_rst,             // power-on or brown-out reset
    input  wire logic [3:0]  i_addr,            // register index
    input  wire logic [7:0]  i_wdata,           // write data
    input  wire logic        i_wr,              // write strobe
    input  wire logic        i_rd,              // read strobe
    output logic      [7:0]  o_rdata,           // read data, cycle after strobe
    input  wire logic        i_ext_clk_pin,     // external clock pin, asynchronous
    input  wire logic        i_aux_osc_clk,     // aux oscillator output, asynchronous
    input  wire logic [1:0]  i_port_direction,  // direction bits of the two pins, 1 = in
    output logic      [1:0]  o_osc_pin_oe,      // pin output enables
    output logic             o_aux_osc_run,     // aux oscillator run request
    input  wire logic [3:0]  i_compare_mode,    // compare unit mode select
    input  wire logic        i_trigger,         // compare unit event pulse
    input  wire logic [15:0] i_compare_value,   // compare register pair
    output logic             o_period_match,    // count equals compare pair
    output logic [15:0]      o_count,           // live count
    output logic             o_irq              // overflow interrupt request
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    tmr_pkg::counter_ctrl_t ctrl;
    tmr_pkg::reg_req_t      req;
    logic [7:0]             companion;
    logic [7:0]             enables;
    logic [7:0]             priority_bits;
    logic                   overflow_flag;
    logic [15:0]            count;
    logic [7:0]             high_buffer;
    logic [2:0]             pre_cnt;
    logic                   src_s3;
    logic                   src_s4;
    logic                   src_seen_low;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    wire logic aux_osc_enable = companion[tmr_pkg::BIT_AUX_OSC_EN];
    wire logic overflow_irq_enable = enables[tmr_pkg::BIT_OVERFLOW];

    ////////////////////////////////////////////////////////////////////////
    // address decode
    wire logic hit_low   = (req.addr == tmr_pkg::OFS_COUNT_LOW);
    wire logic hit_high  = (req.addr == tmr_pkg::OFS_COUNT_HIGH);
    wire logic hit_ctrl  = (req.addr == tmr_pkg::OFS_COUNTER_CTRL);
    wire logic hit_comp  = (req.addr == tmr_pkg::OFS_COMPANION_CTRL);
    wire logic hit_flags = (req.addr == tmr_pkg::OFS_PERIPH_FLAGS);
    wire logic hit_en    = (req.addr == tmr_pkg::OFS_PERIPH_ENABLES);
    wire logic hit_prio  = (req.addr == tmr_pkg::OFS_PERIPH_PRIO);

    wire logic wide     = ctrl.wide_access_enable;
    wire logic wr_low   = req.wr && hit_low;
    wire logic wr_high  = req.wr && hit_high;
    // wide mode: high byte parks in the buffer until the low byte lands
    wire logic cnt_wr   = wr_low || (wr_high && !wide);
    wire logic [15:0] cnt_wr_value = wr_low
        ? (wide ? {high_buffer, req.wdata} : {count[15:8], req.wdata})
        : {req.wdata, count[7:0]};

    ////////////////////////////////////////////////////////////////////////
    // pins and oscillator
    assign o_aux_osc_run = aux_osc_enable;
    // direction bit 0 means the port drives the pin
    assign o_osc_pin_oe = aux_osc_enable ? 2'b00 : ~i_port_direction;

    // source chosen before the flops so one path serves both
    wire logic ext_src_raw = aux_osc_enable ? i_aux_osc_clk : i_ext_clk_pin;
    logic src_s2;

    pin_sync #(
        .STAGES (tmr_pkg::SYNC_STAGES)
    ) u_src_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_pin      (ext_src_raw),
        .o_level    (src_s2)
    );

    // extra stage aligns the edge to the core clock in synchronous mode
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            src_s3 <= 1'b0;
            src_s4 <= 1'b0;
        end else begin
            src_s3 <= src_s2;
            src_s4 <= src_s3;
        end
    end

    // the pins are always sampled twice; bypass only drops the alignment stage
    wire logic edge_async = src_s2 && !src_s3;
    wire logic edge_sync  = src_s3 && !src_s4;
    wire logic ext_edge_any = ctrl.sync_bypass ? edge_async : edge_sync;

    // first counted edge must follow a low level after selecting the pin
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            src_seen_low <= 1'b0;
        end else if (!ctrl.clock_source_select || !ctrl.counter_run) begin
            src_seen_low <= 1'b0;
        end else if (!src_s3) begin
            src_seen_low <= 1'b1;
        end
    end

    wire logic ext_edge = ext_edge_any && src_seen_low;
    // internal source ticks every instruction cycle
    wire logic src_tick = ctrl.clock_source_select ? ext_edge : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // prescaler
    logic [2:0] pre_mask;
    always_comb begin
        unique case (ctrl.input_prescale_select)
            2'b00: pre_mask = 3'h0;
            2'b01: pre_mask = 3'h1;
            2'b10: pre_mask = 3'h3;
            2'b11: pre_mask = 3'h7;
        endcase
    end

    wire logic pre_done = ((pre_cnt & pre_mask) == pre_mask);
    wire logic inc = ctrl.counter_run && src_tick && pre_done;

    // cleared on every control write so a new ratio starts clean
    always_ff @(posedge i_core_clk) begin
        if (i_rst || (req.wr && hit_ctrl)) begin
            pre_cnt <= 3'h0;
        end else if (ctrl.counter_run && src_tick) begin
            pre_cnt <= pre_done ? 3'h0 : pre_cnt + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter
    wire logic trig_take = i_trigger && (i_compare_mode == tmr_pkg::MODE_SPECIAL_TRIGGER);
    wire logic wrap = inc && !cnt_wr && !trig_take && (count == tmr_pkg::COUNT_MAX);
    // the compare unit fires on this match; its trigger closes the period
    assign o_period_match = (count == i_compare_value);

    logic [15:0] next_count;
    always_comb begin
        if (cnt_wr) begin
            next_count = cnt_wr_value;
        end else if (trig_take) begin
            next_count = tmr_pkg::COUNT_ZERO;
        end else if (inc) begin
            next_count = count + tmr_pkg::COUNT_ONE;
        end else begin
            next_count = count;
        end
    end

    // no reset: the count survives everything but power loss
    always_ff @(posedge i_core_clk) begin
        count <= next_count;
    end

    assign o_count = count;

    ////////////////////////////////////////////////////////////////////////
    // wide access buffer: loads on low-byte read or high-byte write
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            high_buffer <= 8'h00;
        end else if (wide && req.rd && hit_low) begin
            high_buffer <= count[15:8];
        end else if (wide && wr_high) begin
            high_buffer <= req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl          <= tmr_pkg::RST_COUNTER_CTRL;
            companion     <= tmr_pkg::RST_COMPANION_CTRL;
            enables       <= tmr_pkg::RST_PERIPH;
            priority_bits <= tmr_pkg::RST_PERIPH;
        end else if (req.wr) begin
            if (hit_ctrl) begin
                ctrl <= req.wdata;
            end
            if (hit_comp) begin
                companion <= req.wdata & tmr_pkg::COMPANION_MASK;
            end
            if (hit_en) begin
                enables <= req.wdata & tmr_pkg::PERIPH_MASK;
            end
            if (hit_prio) begin
                priority_bits <= req.wdata & tmr_pkg::PERIPH_MASK;
            end
        end
    end

    // set wins over a software clear in the same cycle
    wire logic flag_clr = req.wr && hit_flags && !req.wdata[tmr_pkg::BIT_OVERFLOW];
    wire logic flag_set_sw = req.wr && hit_flags && req.wdata[tmr_pkg::BIT_OVERFLOW];

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            overflow_flag <= 1'b0;
        end else if (wrap || flag_set_sw) begin
            overflow_flag <= 1'b1;
        end else if (flag_clr) begin
            overflow_flag <= 1'b0;
        end
    end

    assign o_irq = overflow_flag && overflow_irq_enable;

    ////////////////////////////////////////////////////////////////////////
    // read path
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (hit_low) begin
            rd_mux = count[7:0];
        end else if (hit_high) begin
            rd_mux = wide ? high_buffer : count[15:8];
        end else if (hit_ctrl) begin
            rd_mux = ctrl;
        end else if (hit_comp) begin
            rd_mux = companion;
        end else if (hit_flags) begin
            rd_mux = {6'h00, overflow_flag, 1'b0};
        end else if (hit_en) begin
            rd_mux = enables;
        end else if (hit_prio) begin
            rd_mux = priority_bits;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst || !req.rd) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_WRITE_WINS: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_low && !wide && trig_take) |=> (count[7:0] == $past(i_wdata))
    ) else $error("trigger overrode a count write");

    AST_TRIG_RESET: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (trig_take && !cnt_wr) |=> (count == 16'h0000)
    ) else $error("trigger did not clear the count");

    AST_TRIG_NO_FLAG: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (trig_take && !overflow_flag && !(req.wr && hit_flags)) |=> !overflow_flag
    ) else $error("trigger set the overflow flag");

    AST_WRAP_FLAG: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (inc && !cnt_wr && !trig_take && count == 16'hFFFF)
            |=> (count == 16'h0000) && overflow_flag
    ) else $error("wrap missed count or flag");

    AST_STOPPED: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (!ctrl.counter_run && !cnt_wr && !trig_take) |=> $stable(count)
    ) else $error("count moved while stopped");

    AST_INTERNAL_EVERY_CYCLE: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (ctrl.counter_run && !ctrl.clock_source_select
            && ctrl.input_prescale_select == 2'b00 && !cnt_wr && !trig_take)
            |=> (count == $past(count) + 16'h0001)
    ) else $error("internal clock did not advance every cycle");

    AST_DIV8_SPACING: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (inc && ctrl.input_prescale_select == 2'b11 && !(req.wr && hit_ctrl))
            |=> !inc [*7]
    ) else $error("divide by eight advanced too early");

    AST_IRQ_FOLLOWS: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (wrap && overflow_irq_enable && !(req.wr && hit_en)) |=> o_irq
    ) else $error("enabled overflow gave no interrupt");

    AST_PINS_INPUT: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        aux_osc_enable |-> (o_osc_pin_oe == 2'b00) && o_aux_osc_run
    ) else $error("oscillator pins driven while enabled");

    AST_RDATA_ONE_CYCLE: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !i_rd |=> (o_rdata == 8'h00)
    ) else $error("read data outside the answer cycle");

endmodule // timer16_core

// ==== bench/timer_far_side.sv ====
module timer_far_side (
    input  wire logic        i_core_clk,       // core clock
    input  wire logic [15:0] i_count,          // live count seen by the compare unit
    input  wire logic [3:0]  i_mode,           // compare unit mode
    input  wire logic [15:0] i_compare_value,  // compare pair
    output logic             o_trigger,        // event pulse on a match
    output logic             o_ext_clk_pin,    // external clock pin
    output logic             o_aux_osc_clk     // aux oscillator output
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // match against the pair clears the count next edge, so the pair is the period
    assign o_trigger = (i_mode == tmr_pkg::MODE_SPECIAL_TRIGGER)
                       && (i_count === i_compare_value);

    ////////////////////////////////////////////////////////////////////////
    // clocks stand still low between bursts
    initial begin
        o_ext_clk_pin = 1'b0;
        o_aux_osc_clk = 1'b0;
    end

    task automatic send_edges(input int n, input bit aux);
        repeat (n) begin
            if (aux) o_aux_osc_clk <= 1'b1;
            else o_ext_clk_pin <= 1'b1;
            repeat (3) @(posedge i_core_clk);
            o_aux_osc_clk <= 1'b0;
            o_ext_clk_pin <= 1'b0;
            repeat (3) @(posedge i_core_clk);
        end
    endtask
endmodule  // timer_far_side

// ==== bench/timer16_core_tb.sv ====
module timer16_core_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] delta;
    } row_t;

    logic        i_core_clk       = 1'b0;
    logic        i_rst            = 1'b1;
    logic [3:0]  i_addr           = 4'h0;
    logic [7:0]  i_wdata          = 8'h00;
    logic        i_wr             = 1'b0;
    logic        i_rd             = 1'b0;
    logic [1:0]  i_port_direction = 2'b00;
    logic [3:0]  i_compare_mode   = 4'h0;
    logic [15:0] i_compare_value  = 16'h0000;
    logic [7:0]  o_rdata;
    logic [1:0]  o_osc_pin_oe;
    logic        o_aux_osc_run;
    logic        o_period_match;
    logic        o_irq;
    logic        trig;
    logic        ext_pin;
    logic        aux_clk;
    logic [15:0] o_count;
    logic [15:0] a;
    logic [15:0] hi;
    int          fails    = 0;
    int          compares = 0;
    logic [3:0]  ra [4] = '{4'h3, 4'h4, 4'h5, 4'h6};
    logic [7:0]  re [4] = '{8'hBF, 8'h02, 8'h4F, 8'h4F};
    row_t        rows [7] = '{'{8'h01, 16'h0010}, '{8'h11, 16'h0008}, '{8'h21, 16'h0004},
                              '{8'h31, 16'h0002}, '{8'h00, 16'h0000}, '{8'h03, 16'h0000},
                              '{8'h05, 16'h0010}};

    always #20 i_core_clk = ~i_core_clk;

    timer16_core u_dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk_pin(ext_pin),
        .i_aux_osc_clk(aux_clk), .i_port_direction(i_port_direction),
        .o_osc_pin_oe(o_osc_pin_oe), .o_aux_osc_run(o_aux_osc_run),
        .i_compare_mode(i_compare_mode), .i_trigger(trig), .i_compare_value(i_compare_value),
        .o_period_match(o_period_match), .o_count(o_count), .o_irq(o_irq)
    );

    timer_far_side u_far (
        .i_core_clk(i_core_clk), .i_count(o_count), .i_mode(i_compare_mode),
        .i_compare_value(i_compare_value), .o_trigger(trig), .o_ext_clk_pin(ext_pin),
        .o_aux_osc_clk(aux_clk)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        i_addr  <= ad;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr    <= 1'b0;
        // idle edge: the next call never raises the strobe in the step that lowered it
        @(posedge i_core_clk);
    endtask

    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        i_addr <= ad;
        i_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_rd   <= 1'b0;
        @(negedge i_core_clk);
        chk({8'h00, o_rdata}, {8'h00, e});
        @(posedge i_core_clk);
    endtask

    // high first: in wide mode it lands in the buffer until the low write
    task automatic set_count(input logic [15:0] v);
        wr(tmr_pkg::OFS_COUNT_HIGH, v[15:8]);
        wr(tmr_pkg::OFS_COUNT_LOW, v[7:0]);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_core_clk);
        fails++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        // count has no reset: load it while reset holds so it is never unknown
        i_addr <= tmr_pkg::OFS_COUNT_LOW;
        i_wr   <= 1'b1;
        @(posedge i_core_clk);
        i_addr <= tmr_pkg::OFS_COUNT_HIGH;
        @(posedge i_core_clk);
        i_wr   <= 1'b0;
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(4'(i), 8'h00);
        rd(4'hF, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ra[i], 8'hFF);
            rd(ra[i], re[i]);
        end
        chk({15'h0000, o_irq}, 16'h0001);
        for (int i = 0; i < 4; i++) wr(ra[i], 8'h00);
        set_count(16'h0000);
        for (int i = 0; i < 7; i++) begin
            wr(tmr_pkg::OFS_COUNTER_CTRL, rows[i].ctrl);
            repeat (4) @(posedge i_core_clk);
            @(negedge i_core_clk);
            a = o_count;
            repeat (16) @(negedge i_core_clk);
            chk(o_count - a, rows[i].delta);
            @(posedge i_core_clk);
        end
        // wrap from the top end
        wr(tmr_pkg::OFS_COUNTER_CTRL, 8'h00);
        wr(tmr_pkg::OFS_PERIPH_ENABLES, 8'h02);
        set_count(16'hFFFD);
        wr(tmr_pkg::OFS_COUNTER_CTRL, 8'h01);
        repeat (8) @(posedge i_core_clk);
        wr(tmr_pkg::OFS_COUNTER_CTRL, 8'h00);
        chk(o_count & 16'hFFF0, 16'h0000);
        rd(tmr_pkg::OFS_PERIPH_FLAGS, 8'h02);
        chk({15'h0000, o_irq}, 16'h0001);
        wr(tmr_pkg::OFS_PERIPH_ENABLES, 8'h00);
        @(negedge i_core_clk);
        chk({15'h0000, o_irq}, 16'h0000);
        @(posedge i_core_clk);
        // trigger clears only in the special mode; clears never raise the flag
        for (int m = 0; m < 2; m++) begin
            wr(tmr_pkg::OFS_PERIPH_FLAGS, 8'h00);
            i_compare_value <= 16'h0009;
            i_compare_mode  <= (m == 0) ? 4'b1011 : 4'b1010;
            set_count(16'h0000);
            wr(tmr_pkg::OFS_COUNTER_CTRL, 8'h01);
            hi = 16'h0000;
            repeat (40) @(negedge i_core_clk) if (o_count > hi) hi = o_count;
            @(posedge i_core_clk);
            wr(tmr_pkg::OFS_COUNTER_CTRL, 8'h00);
            chk({15'h0000, hi == 16'h0009}, (m == 0) ? 16'h0001 : 16'h0000);
            rd(tmr_pkg::OFS_PERIPH_FLAGS, 8'h00);
        end
        // count write against a trigger in the same cycle
        i_compare_mode  <= 4'b1010;
        i_compare_value <= 16'h0005;
        set_count(16'h0005);
        @(negedge i_core_clk);
        chk({15'h0000, o_period_match}, 16'h0001);
        @(posedge i_core_clk);
        i_compare_mode  <= 4'b1011;
        wr(tmr_pkg::OFS_COUNT_LOW, 8'h33);
        @(negedge i_core_clk);
        chk(o_count, 16'h0033);
        chk({15'h0000, o_period_match}, 16'h0000);
        @(posedge i_core_clk);
        i_compare_value <= 16'h0033;
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk(o_count, 16'h0000);
        @(posedge i_core_clk);
        i_compare_mode <= 4'h0;
        // one sixteen-bit access through the high byte buffer
        wr(tmr_pkg::OFS_COUNTER_CTRL, 8'h80);
        wr(tmr_pkg::OFS_COUNT_HIGH, 8'hAB);
        chk(o_count, 16'h0000);
        wr(tmr_pkg::OFS_COUNT_LOW, 8'hCD);
        chk(o_count, 16'hABCD);
        rd(tmr_pkg::OFS_COUNT_LOW, 8'hCD);
        rd(tmr_pkg::OFS_COUNT_HIGH, 8'hAB);
        // pin, synchronised and bypassed, then the aux oscillator
        for (int k = 0; k < 3; k++) begin
            wr(tmr_pkg::OFS_COMPANION_CTRL, (k == 2) ? 8'h08 : 8'h00);
            set_count(16'h0000);
            wr(tmr_pkg::OFS_COUNTER_CTRL, (k == 1) ? 8'h07 : 8'h03);
            repeat (4) @(posedge i_core_clk);
            u_far.send_edges(5, k == 2);
            repeat (8) @(posedge i_core_clk);
            chk(o_count, 16'h0005);
            chk({15'h0000, o_aux_osc_run}, (k == 2) ? 16'h0001 : 16'h0000);
            chk({14'h0000, o_osc_pin_oe}, (k == 2) ? 16'h0000 : 16'h0003);
            wr(tmr_pkg::OFS_COUNTER_CTRL, 8'h00);
        end
        // reset while stopped in wide mode clears the control but keeps the count
        set_count(16'h1234);
        wr(tmr_pkg::OFS_COUNTER_CTRL, 8'h80);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd(tmr_pkg::OFS_COUNTER_CTRL, 8'h00);
        @(negedge i_core_clk);
        chk(o_count, 16'h1234);
        stop_test();
    end
endmodule  // timer16_core_tb
